// file: verilog/nvmpe_consts.svh
/*
  Constants of the flash and EEPROM program/erase control block: timing,
  field positions and widths.
  Assumes inclusion by bare name from the design modules.
*/
// Contract
// R1: Flash programs one whole 64-byte row
// R2: Flash erase always clears whole array
// R3: Flash program and erase take fixed time
// R4: EEPROM time base from external clock input
// R5: Ten-bit divider in two registers, software-set
// R6: Divider registers reload from shadow at reset
// R7: Automatic-timing enable sits at control bit 5
// R8: Auto mode times operation, clears pulse bit
// R9: Manual mode: software holds minimum time
// R10: Up to eight writes then erase: one cycle
// R11: Manual mode: pulse bit stays until cleared
`ifndef NVMPE_CONSTS_SVH
`define NVMPE_CONSTS_SVH

`define NVMPE_CLK_NS        40
`define NVMPE_ROW_BYTES     64
`define NVMPE_ROW_ADDR_W    10
`define NVMPE_DIV_W         10
`define NVMPE_DIV_HI_W      2
`define NVMPE_DIV_LO_W      8
`define NVMPE_FL_PROG_US    40
`define NVMPE_FL_ERASE_US   20000
`define NVMPE_FL_PROG_CYC   ((`NVMPE_FL_PROG_US * 1000 + `NVMPE_CLK_NS - 1) / `NVMPE_CLK_NS)
`define NVMPE_FL_ERASE_CYC  ((`NVMPE_FL_ERASE_US * 1000 + `NVMPE_CLK_NS - 1) / `NVMPE_CLK_NS)
`define NVMPE_EE_AUTO_TICKS 16
`define NVMPE_EE_PGM_BIT    0
`define NVMPE_EE_LATCH_BIT  1
`define NVMPE_EE_ERASE_BIT  2
`define NVMPE_EE_AUTO_BIT   5
`define NVMPE_EE_CTL_MASK   8'h27
`define NVMPE_FL_PROG_BIT   0
`define NVMPE_FL_ERASE_BIT  1

`endif

// file: verilog/nvmpe_pkg.sv
/*
  Types of the flash and EEPROM program/erase control block.
  Assumes nothing beyond the constants header.
*/
package nvmpe_pkg;
  typedef enum logic [1:0] {
    FL_IDLE,
    FL_PROG_WAIT,
    FL_PROG_WRITE,
    FL_ERASE_WAIT
  } nvmpe_fl_state_t;
endpackage

// file: verilog/nvmpe_tick_if.sv
/*
  Link between the control core and its EEPROM time-base divider.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
interface nvmpe_tick_if;
  logic       ext_clk;  // External clock input level
  logic [9:0] ratio;    // Divider setting, divide by ratio+1
  logic       tick;     // One-cycle time-base enable
  modport src (output ext_clk, output ratio, input tick);
  modport gen (input ext_clk, input ratio, output tick);
endinterface

// file: verilog/nvmpe_tick.sv
/*
  EEPROM time-base divider: counts rising edges of the external clock input
  and pulses one tick every ratio+1 edges.
  Assumes the external clock input is synchronous to clk_sys and slower than
  half its rate.
*/
`timescale 1ns/10ps
`include "nvmpe_consts.svh"
module nvmpe_tick
  import nvmpe_pkg::*;
#(
  parameter int DIV_W = `NVMPE_DIV_W
) (
  input wire logic clk_sys,      // System clock
  input wire logic rstn,         // Asynchronous reset, active low
  nvmpe_tick_if.gen tb           // Divider link
);
  logic             ext_prev_r;
  logic [DIV_W-1:0] cnt_r;
  logic             tick_r;
  logic             ext_rise;

  initial begin
    if (DIV_W != 10) $error("nvmpe_tick: divider must be 10 bits wide");
  end

  // Edge of the external clock, not the bus clock, drives the time base
  assign ext_rise = tb.ext_clk & ~ext_prev_r; // R4

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ext_prev_r <= 1'b1; // A high oscillator level at release is no edge
    end else begin
      ext_prev_r <= tb.ext_clk;
    end
  end

  // Edge counter; a new ratio is compared from the next edge on, even mid-count
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (ext_rise) begin
        if (cnt_r >= tb.ratio) begin // R5
          cnt_r  <= '0;
          tick_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

  assign tb.tick = tick_r;

  AST_TICK_FROM_EXT: assert property (@(posedge clk_sys) disable iff (!rstn) // R4
    tick_r |-> $past(ext_rise))
    else $error("Time-base tick without an external clock edge");
endmodule

// file: verilog/nvmpe_top.sv
/*
  Flash and EEPROM program/erase control. Flash: one 64-byte row buffer,
  programmed after a fixed delay, or the whole array erased after a fixed
  delay. EEPROM: control bits, divider registers and automatic timing.
  Assumes the array cells sit outside and take cell_wr and cell_erase_all;
  register writes are single-cycle strobes from a bus decoder elsewhere.
*/
`timescale 1ns/10ps
`include "nvmpe_consts.svh"
module nvmpe_top
  import nvmpe_pkg::*;
#(
  parameter int ROW_BYTES    = `NVMPE_ROW_BYTES,
  parameter int ROW_ADDR_W   = `NVMPE_ROW_ADDR_W,
  parameter int FL_ERASE_CYC = `NVMPE_FL_ERASE_CYC,
  parameter int EE_AUTO_TICKS = `NVMPE_EE_AUTO_TICKS
) (
  input  wire logic                  clk_sys,               // System clock, 25 MHz
  input  wire logic                  rstn,                  // Async reset, active low
  input  wire logic                  external_clock_input,  // Oscillator input level
  input  wire logic [9:0]            shadow_div,            // Non-volatile divider word
  input  wire logic                  div_high_wr,           // Write strobe, divider high
  input  wire logic                  div_low_wr,            // Write strobe, divider low
  input  wire logic [7:0]            div_wdata,             // Divider write data
  output logic [1:0]                 eeprom_divider_high,   // Divider bits 9:8
  output logic [7:0]                 eeprom_divider_low,    // Divider bits 7:0
  input  wire logic                  ee_ctl_wr,             // Write strobe, EEPROM control
  input  wire logic [7:0]            ee_ctl_wdata,          // EEPROM control write data
  output logic [7:0]                 eeprom_program_control, // EEPROM control readback
  output logic                       ee_hv_on,              // Program/erase voltage on
  input  wire logic                  flash_ctl_wr,          // Write strobe, flash control
  input  wire logic [7:0]            flash_ctl_wdata,       // Flash command bits
  output logic [7:0]                 flash_control,         // Flash busy status
  input  wire logic [ROW_ADDR_W-1:0] flash_row_addr,        // Row to program
  input  wire logic                  row_wr,                // Row buffer byte write
  input  wire logic [5:0]            row_idx,               // Byte within row
  input  wire logic [7:0]            row_data,              // Row buffer data
  output logic                       cell_wr,               // Array byte write
  output logic [ROW_ADDR_W+5:0]      cell_addr,             // Array byte address
  output logic [7:0]                 cell_data,             // Array byte data
  output logic                       cell_erase_all         // Whole-array erase pulse
);
  localparam logic [31:0] PROG_CYC  = 32'(`NVMPE_FL_PROG_CYC);
  localparam logic [31:0] ERASE_CYC = 32'(FL_ERASE_CYC);
  localparam logic [7:0]  AUTO_TKS  = 8'(EE_AUTO_TICKS);

  nvmpe_tick_if tb ();
  nvmpe_fl_state_t fl_state_r;
  logic [31:0]    fl_cnt_r;
  logic [5:0]     byte_r;
  logic [7:0]     row_buf_r [ROW_BYTES];
  logic           cell_wr_r;
  logic [ROW_ADDR_W+5:0] cell_addr_r;
  logic [7:0]     cell_data_r;
  logic           cell_erase_r;
  logic           div_load_r;
  logic [1:0]     div_hi_r;
  logic [7:0]     div_lo_r;
  logic [7:0]     ee_ctl_r;
  logic [7:0]     ee_cnt_r;
  logic           ee_auto_done;
  logic [6:0]     wr_run_r;

  initial begin
    if (ROW_BYTES != 64) $error("nvmpe_top: row buffer must be 64 bytes");
    if (EE_AUTO_TICKS < 1 || EE_AUTO_TICKS > 255) $error("nvmpe_top: bad auto tick count");
    if (FL_ERASE_CYC < 2) $error("nvmpe_top: erase count too small");
  end

  // Divider: the wrap of the time base follows the full ten bits
  assign tb.ext_clk = external_clock_input;
  assign tb.ratio   = {div_hi_r, div_lo_r}; // R5

  nvmpe_tick #(
    .DIV_W (`NVMPE_DIV_W)
  ) u_tick (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .tb      (tb)
  );

  // Divider registers; shadow copy is caught on the first edge after reset,
  // since an async reset may only load constants. Writes that cycle are lost.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_load_r <= 1'b1;
      div_hi_r   <= '0;
      div_lo_r   <= '0;
    end else if (div_load_r) begin
      div_load_r <= 1'b0;
      div_hi_r   <= shadow_div[9:8]; // R6
      div_lo_r   <= shadow_div[7:0]; // R6
    end else begin
      if (div_high_wr) begin
        div_hi_r <= div_wdata[1:0]; // R5
      end
      if (div_low_wr) begin
        div_lo_r <= div_wdata; // R5
      end
    end
  end

  assign eeprom_divider_high = div_hi_r;
  assign eeprom_divider_low  = div_lo_r;

  // Auto mode ends the pulse after a fixed number of time-base ticks
  assign ee_auto_done = ee_ctl_r[`NVMPE_EE_AUTO_BIT] & ee_ctl_r[`NVMPE_EE_PGM_BIT] &
                        tb.tick & (ee_cnt_r == AUTO_TKS - 8'h01); // R8 R11

  // Tick counter runs only while an automatic pulse is in progress
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ee_cnt_r <= '0;
    end else if (!(ee_ctl_r[`NVMPE_EE_AUTO_BIT] & ee_ctl_r[`NVMPE_EE_PGM_BIT])) begin
      ee_cnt_r <= '0;
    end else if (tb.tick) begin
      ee_cnt_r <= ee_auto_done ? 8'h00 : ee_cnt_r + 8'h01;
    end
  end

  // EEPROM control; a software write wins over the automatic clear so a
  // freshly set pulse is never dropped. Manual pulses never end by themselves.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ee_ctl_r <= 8'h00;
    end else if (ee_ctl_wr) begin
      ee_ctl_r <= ee_ctl_wdata & `NVMPE_EE_CTL_MASK; // R7
    end else if (ee_auto_done) begin
      ee_ctl_r[`NVMPE_EE_PGM_BIT] <= 1'b0; // R8
    end
  end

  assign eeprom_program_control = ee_ctl_r;
  // Selective writes and minimum manual time are software's to respect
  assign ee_hv_on = ee_ctl_r[`NVMPE_EE_PGM_BIT] & ee_ctl_r[`NVMPE_EE_LATCH_BIT]; // R9 R10

  // Row buffer; loads are ignored while an operation runs
  always_ff @(posedge clk_sys) begin
    if (row_wr && fl_state_r == FL_IDLE) begin
      row_buf_r[row_idx] <= row_data; // R1
    end
  end

  // Flash sequencer: fixed wait, then whole-row burst or whole-array erase
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fl_state_r   <= FL_IDLE;
      fl_cnt_r     <= '0;
      byte_r       <= '0;
      cell_wr_r    <= 1'b0;
      cell_addr_r  <= '0;
      cell_data_r  <= 8'h00;
      cell_erase_r <= 1'b0;
    end else begin
      cell_wr_r    <= 1'b0;
      cell_erase_r <= 1'b0;
      case (fl_state_r)
        FL_IDLE: begin
          fl_cnt_r <= '0;
          byte_r   <= '0;
          if (flash_ctl_wr && flash_ctl_wdata[`NVMPE_FL_ERASE_BIT]) begin
            fl_state_r <= FL_ERASE_WAIT; // R2
          end else if (flash_ctl_wr && flash_ctl_wdata[`NVMPE_FL_PROG_BIT]) begin
            fl_state_r <= FL_PROG_WAIT; // R1
          end
        end
        FL_PROG_WAIT: begin
          fl_cnt_r <= fl_cnt_r + 32'h1;
          if (fl_cnt_r == PROG_CYC - 32'h1) begin
            fl_state_r <= FL_PROG_WRITE; // R3
          end
        end
        FL_PROG_WRITE: begin
          cell_wr_r   <= 1'b1;
          cell_data_r <= row_buf_r[byte_r];
          cell_addr_r <= {flash_row_addr, byte_r}; // R1
          byte_r      <= byte_r + 6'h01;
          if (byte_r == 6'h3F) begin
            fl_state_r <= FL_IDLE;
          end
        end
        FL_ERASE_WAIT: begin
          fl_cnt_r <= fl_cnt_r + 32'h1;
          if (fl_cnt_r == ERASE_CYC - 32'h1) begin
            cell_erase_r <= 1'b1; // R2 R3
            fl_state_r   <= FL_IDLE;
          end
        end
        default: begin
          fl_state_r <= FL_IDLE;
        end
      endcase
    end
  end

  assign cell_wr        = cell_wr_r;
  assign cell_addr      = cell_addr_r;
  assign cell_data      = cell_data_r;
  assign cell_erase_all = cell_erase_r;
  assign flash_control  = {6'h00, fl_state_r == FL_ERASE_WAIT,
                           fl_state_r == FL_PROG_WAIT || fl_state_r == FL_PROG_WRITE};

  // Length of each array write burst, read only by the checks
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_run_r <= '0;
    end else begin
      wr_run_r <= cell_wr_r ? wr_run_r + 7'h01 : 7'h00;
    end
  end

  AST_FL_ROW_BURST: assert property (@(posedge clk_sys) disable iff (!rstn) // R1
    $fell(cell_wr_r) |-> wr_run_r == 7'd64)
    else $error("Flash burst did not write one whole row");

  AST_FL_ERASE_WHOLE: assert property (@(posedge clk_sys) disable iff (!rstn) // R2
    cell_erase_r |-> !cell_wr_r && $past(fl_state_r) == FL_ERASE_WAIT && fl_state_r == FL_IDLE)
    else $error("Erase pulse outside the erase sequence");

  AST_FL_PROG_FIXED: assert property (@(posedge clk_sys) disable iff (!rstn) // R3
    $rose(fl_state_r == FL_PROG_WRITE) |-> $past(fl_cnt_r) == PROG_CYC - 32'h1)
    else $error("Flash program wait not of fixed length");

  AST_DIV_SHADOW: assert property (@(posedge clk_sys) disable iff (!rstn) // R6
    div_load_r |=> {div_hi_r, div_lo_r} == $past(shadow_div) && !div_load_r)
    else $error("Divider not loaded from shadow word after reset");

  AST_EE_AUTO_CLEAR: assert property (@(posedge clk_sys) disable iff (!rstn) // R8
    ee_auto_done && !ee_ctl_wr |=> !ee_ctl_r[`NVMPE_EE_PGM_BIT])
    else $error("Automatic timing did not clear the pulse bit");

  AST_EE_MANUAL_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn) // R11
    ee_ctl_r[`NVMPE_EE_PGM_BIT] && !ee_ctl_r[`NVMPE_EE_AUTO_BIT] && !ee_ctl_wr
    |=> ee_ctl_r[`NVMPE_EE_PGM_BIT])
    else $error("Manual pulse ended without software");

  AST_EE_AUTO_BIT5: assert property (@(posedge clk_sys) disable iff (!rstn) // R7
    ee_ctl_wr |=> ee_ctl_r[5] == $past(ee_ctl_wdata[5]))
    else $error("Automatic-timing enable not at bit 5");

  AST_DIV_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn) // R5
    div_low_wr && !div_load_r |=> div_lo_r == $past(div_wdata))
    else $error("Divider low write lost");
endmodule

// file: tb/tb.sv
/*
  Self-checking bench for the flash and EEPROM program/erase control block.
  Assumes one 25 MHz clock; inputs change on the falling edge.
*/
`timescale 1ns/10ps
module tb;
  import nvmpe_pkg::*;
  localparam int ERASE_CYC = 20;
  logic        clk_sys, rstn, external_clock_input, div_high_wr, div_low_wr;
  logic        ee_ctl_wr, flash_ctl_wr, row_wr, ee_hv_on, cell_wr, cell_erase_all;
  logic [9:0]  shadow_div, flash_row_addr;
  logic [7:0]  div_wdata, ee_ctl_wdata, flash_ctl_wdata, row_data, cell_data;
  logic [7:0]  eeprom_divider_low, eeprom_program_control, flash_control;
  logic [1:0]  eeprom_divider_high;
  logic [5:0]  row_idx;
  logic [15:0] cell_addr;
  logic [15:0] got_addr [64];
  logic [7:0]  got_data [64];
  int          err_count, checked, cyc, wr_cnt, erase_cnt, first_wr, erase_at;
  int          ext_div, ext_edges, t0;
  bit          ext_run;

  nvmpe_top #(.FL_ERASE_CYC(ERASE_CYC)) u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .external_clock_input(external_clock_input),
    .shadow_div(shadow_div), .div_high_wr(div_high_wr), .div_low_wr(div_low_wr),
    .div_wdata(div_wdata), .eeprom_divider_high(eeprom_divider_high),
    .eeprom_divider_low(eeprom_divider_low), .ee_ctl_wr(ee_ctl_wr),
    .ee_ctl_wdata(ee_ctl_wdata), .eeprom_program_control(eeprom_program_control),
    .ee_hv_on(ee_hv_on), .flash_ctl_wr(flash_ctl_wr), .flash_ctl_wdata(flash_ctl_wdata),
    .flash_control(flash_control), .flash_row_addr(flash_row_addr), .row_wr(row_wr),
    .row_idx(row_idx), .row_data(row_data), .cell_wr(cell_wr), .cell_addr(cell_addr),
    .cell_data(cell_data), .cell_erase_all(cell_erase_all));

  // Clock, 40 ns period
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Cycle count; the ceiling sits well above the longest expected run
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  // Oscillator input: period of 8 system cycles, stands still unless enabled
  always @(negedge clk_sys) begin
    if (ext_run) begin
      ext_div++;
      if (ext_div == 4) begin
        ext_div = 0;
        if (!external_clock_input) ext_edges++;
        external_clock_input <= ~external_clock_input;
      end
    end
  end

  // Array-side monitor, sampled mid-cycle where registered outputs are settled
  always @(negedge clk_sys) begin
    if (cell_wr === 1'b1) begin
      if (wr_cnt == 0) first_wr = cyc;
      if (wr_cnt < 64) begin
        got_addr[wr_cnt] = cell_addr;
        got_data[wr_cnt] = cell_data;
      end
      wr_cnt++;
    end
    if (cell_erase_all === 1'b1) begin
      erase_at = cyc;
      erase_cnt++;
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // Bench-side counts and delays, checked against a window
  task automatic chk_n(input string name, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("unexpected %s: expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  // One-cycle write strobe: 0 div low, 1 div high, 2 EEPROM ctl, 3 flash ctl, 4 row byte
  task automatic wr(input int sel, input logic [5:0] idx, input logic [7:0] d);
    div_wdata       = d;
    ee_ctl_wdata    = d;
    flash_ctl_wdata = d;
    row_data        = d;
    row_idx         = idx;
    div_low_wr      = (sel == 0);
    div_high_wr     = (sel == 1);
    ee_ctl_wr       = (sel == 2);
    flash_ctl_wr    = (sel == 3);
    row_wr          = (sel == 4);
    @(negedge clk_sys);
    {div_low_wr, div_high_wr, ee_ctl_wr, flash_ctl_wr, row_wr} = 5'h00;
    // One idle edge between strobes, so no strobe is set and cleared at once
    @(negedge clk_sys);
  endtask

  task automatic do_reset(input logic [9:0] s);
    rstn       = 1'b0;
    shadow_div = s;
    repeat (10) @(negedge clk_sys);
    chk("ctl in reset", 16'h0000, {8'h00, eeprom_program_control});
    rstn = 1'b1;
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    {external_clock_input, div_high_wr, div_low_wr, ee_ctl_wr, flash_ctl_wr, row_wr} = 6'h00;
    {div_wdata, ee_ctl_wdata, flash_ctl_wdata, row_data} = 32'h0000_0000;
    {row_idx, flash_row_addr} = 16'h0000;
    {err_count, checked, wr_cnt, erase_cnt, ext_div, ext_edges} = '0;
    ext_run = 1'b0;
    @(negedge clk_sys);
    do_reset(10'h2A5);
    chk("div high", 16'h0002, {14'h0, eeprom_divider_high});
    chk("div low", 16'h00A5, {8'h00, eeprom_divider_low});
    // Ratio 3: a tick on every fourth oscillator edge; upper bits of high write dropped
    wr(0, 6'h00, 8'h03);
    wr(1, 6'h00, 8'hFC);
    chk("div low wr", 16'h0003, {8'h00, eeprom_divider_low});
    chk("div high wr", 16'h0000, {14'h0, eeprom_divider_high});
    // Auto mode with the oscillator stopped: the bus clock alone must not end it
    wr(2, 6'h00, 8'h23);
    chk("ctl auto", 16'h0023, {8'h00, eeprom_program_control});
    repeat (300) @(negedge clk_sys);
    chk("ctl stalled", 16'h0023, {8'h00, eeprom_program_control});
    ext_edges = 0;
    ext_run   = 1'b1;
    for (int i = 0; i < 2000 && eeprom_program_control[0] !== 1'b0; i++) @(negedge clk_sys);
    chk_n("auto edges", 60, 66, ext_edges);
    chk("ctl auto done", 16'h0022, {8'h00, eeprom_program_control});
    chk("hv auto done", 16'h0000, {15'h0, ee_hv_on});
    // Manual mode: unused bits read zero, pulse stays long past the auto time
    wr(2, 6'h00, 8'hDB);
    chk("ctl manual", 16'h0003, {8'h00, eeprom_program_control});
    chk("hv manual", 16'h0001, {15'h0, ee_hv_on});
    repeat (800) @(negedge clk_sys);
    chk("ctl held", 16'h0003, {8'h00, eeprom_program_control});
    wr(2, 6'h00, 8'h00);
    chk("hv off", 16'h0000, {15'h0, ee_hv_on});
    // Selective writes: eight held manual pulses to one location, then one erase
    for (int i = 0; i < 8; i++) begin
      wr(2, 6'h00, 8'h03);
      chk("hv selective", 16'h0001, {15'h0, ee_hv_on});
      repeat (520) @(negedge clk_sys);
      chk("ctl selective", 16'h0003, {8'h00, eeprom_program_control});
      wr(2, 6'h00, 8'h02);
    end
    wr(2, 6'h00, 8'h07);
    chk("ctl sel erase", 16'h0007, {8'h00, eeprom_program_control});
    repeat (520) @(negedge clk_sys);
    wr(2, 6'h00, 8'h00);
    chk("hv sel done", 16'h0000, {15'h0, ee_hv_on});
    // Flash row program; a byte load and an erase while busy are ignored
    flash_row_addr = 10'h155;
    for (int i = 0; i < 64; i++) wr(4, i[5:0], 8'h11 + 8'(i * 3));
    t0 = cyc;
    wr(3, 6'h00, 8'h01);
    chk("flash busy prog", 16'h0001, {8'h00, flash_control});
    wr(4, 6'h00, 8'hEE);
    wr(3, 6'h00, 8'h02);
    for (int i = 0; i < 1500 && !(wr_cnt >= 64 && flash_control === 8'h00); i++)
      @(posedge clk_sys);
    @(negedge clk_sys);
    chk_n("row bytes", 64, 64, wr_cnt);
    chk_n("prog delay", 1001, 1006, first_wr - t0);
    chk_n("erase while busy", 0, 0, erase_cnt);
    for (int i = 0; i < 64; i++) begin
      chk("cell addr", {10'h155, i[5:0]}, got_addr[i]);
      chk("cell data", {8'h00, 8'h11 + 8'(i * 3)}, {8'h00, got_data[i]});
    end
    // Both command bits: erase wins and clears the whole array in one pulse
    t0 = cyc;
    wr(3, 6'h00, 8'h03);
    chk("flash busy erase", 16'h0002, {8'h00, flash_control});
    for (int i = 0; i < 100 && erase_cnt == 0; i++) @(posedge clk_sys);
    repeat (2) @(negedge clk_sys);
    chk_n("erase pulses", 1, 1, erase_cnt);
    chk_n("erase delay", ERASE_CYC - 1, ERASE_CYC + 5, erase_at - t0);
    chk_n("no writes on erase", 64, 64, wr_cnt);
    chk("flash idle", 16'h0000, {8'h00, flash_control});
    // Second reset mid-run reloads the dividers from a new shadow word
    ext_run = 1'b0;
    do_reset(10'h1C3);
    chk("div high again", 16'h0001, {14'h0, eeprom_divider_high});
    chk("div low again", 16'h00C3, {8'h00, eeprom_divider_low});
    give_verdict();
  end
endmodule
